//--- bench/continuous_weight_string_tx_tb_top.sv
// Self-checking bench for the weight string framer.
// Assumes short pacing and bit-rate parameters to keep the run brief.
`timescale 1ns/1ps

module continuous_weight_string_tx_tb_top;
   import cwt_pkg::*;
   localparam int GAP  = 100;
   localparam int BDIV = 8;

   logic        ref_clk;
   logic        reset_n;
   logic        framed_sel;
   logic        stream_en;
   logic        contact_in;
   logic        slow;
   cwt_weight_t weight;
   logic        tx_ready;
   logic        tx_valid;
   logic        baud_tick;
   logic        busy;
   logic [7:0]  tx_data;
   logic [7:0]  exp_q[$];
   int          err_total;
   int          n_compared;

   cwt_framer #(.STRING_GAP_CYC(GAP), .BAUD_DIV(BDIV)) u_cwt_framer (
      .ref_clk(ref_clk), .reset_n(reset_n), .framed_sel(framed_sel),
      .stream_en(stream_en), .contact_in(contact_in), .weight(weight),
      .tx_ready(tx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
      .baud_tick(baud_tick), .busy(busy));

   cwt_host_rx u_cwt_host_rx (
      .ref_clk(ref_clk), .reset_n(reset_n), .slow(slow),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   function automatic logic [47:0] fld(input cwt_weight_t w);
      logic [47:0] f;
      for (int i = 0; i < 6; i++) f[8*i+:8] = 8'h30 + 8'(w.bcd[4*i+:4]);
      if (w.neg) f[47:40] = 8'h2D;
      if (w.alarm) f = w.alarm_text;
      return f;
   endfunction

   function automatic logic [7:0] hx(input logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h41 + 8'(n) - 8'h0A;
   endfunction

   // Bounded wait at falling edges for busy to reach v
   task automatic wb(input logic v);
      int n;
      for (n = 0; busy !== v && n < 400; n++) @(negedge ref_clk);
      chk("busy", busy, v);
   endtask

   task automatic send(input logic fmt, input cwt_weight_t w, input logic sl);
      logic [47:0] f;
      logic [7:0]  cs;
      f = fld(w);
      cs = 8'h00;
      exp_q.delete();
      if (fmt) exp_q.push_back(8'h26);
      if (fmt) exp_q.push_back(8'h54);
      for (int i = 5; i >= 0; i--) exp_q.push_back(f[8*i+:8]);
      if (fmt) begin
         exp_q.push_back(8'h50);
         for (int i = 5; i >= 0; i--) exp_q.push_back(f[8*i+:8]);
         for (int i = 1; i < 15; i++) cs ^= exp_q[i];
         exp_q.push_back(8'h5C);
         exp_q.push_back(hx(cs[7:4]));
         exp_q.push_back(hx(cs[3:0]));
      end
      exp_q.push_back(8'h0D);
      if (!fmt) exp_q.push_back(8'h0A);
      framed_sel = fmt;
      weight = w;
      slow = sl;
      u_cwt_host_rx.rx_q.delete();
      stream_en = 1'b1;
      wb(1'b1);
      stream_en = 1'b0;
      wb(1'b0);
      chk("count", u_cwt_host_rx.rx_q.size(), exp_q.size());
      foreach (exp_q[i]) chk("byte", u_cwt_host_rx.rx_q[i], exp_q[i]);
      repeat (GAP) @(negedge ref_clk);
   endtask

   task automatic s_baud();
      int n;
      n = 0;
      repeat (8 * BDIV) begin
         @(negedge ref_clk);
         n += int'(baud_tick === 1'b1);
      end
      chk("baud_ticks", n, 8);
   endtask

   // Short or long closure alike yields a single string
   task automatic s_contact(input int hold);
      framed_sel = 1'b0;
      u_cwt_host_rx.rx_q.delete();
      for (int n = 0; n < hold + 2 * GAP; n++) begin
         contact_in = (n < hold);
         @(negedge ref_clk);
      end
      chk("trig_count", u_cwt_host_rx.rx_q.size(), 8);
      chk("trig_end", u_cwt_host_rx.rx_q[7], 8'h0A);
   endtask

   task automatic s_rate();
      int n1;
      int n2;
      stream_en = 1'b1;
      wb(1'b1);
      for (n1 = 0; busy === 1'b1 && n1 < 400; n1++) @(negedge ref_clk);
      for (n2 = 0; busy !== 1'b1 && n2 < 400; n2++) @(negedge ref_clk);
      chk("gap", (n1 + n2 >= GAP) && (n1 + n2 <= GAP + 1), 1);
      stream_en = 1'b0;
      wb(1'b0);
      repeat (GAP) @(negedge ref_clk);
   endtask

   initial begin
      err_total = 0;
      n_compared = 0;
      reset_n = 1'b0;
      framed_sel = 1'b0;
      stream_en = 1'b0;
      contact_in = 1'b0;
      slow = 1'b0;
      weight = '0;
      repeat (3) @(negedge ref_clk);
      reset_n = 1'b1;
      s_baud();
      send(1'b0, {1'b0, 1'b0, 24'h01_2345, 48'h0}, 1'b0);
      send(1'b0, {1'b1, 1'b0, 24'h67_8989, 48'h0}, 1'b1);
      send(1'b1, {1'b1, 1'b0, 24'h09_8765, 48'h0}, 1'b1);
      send(1'b1, {1'b0, 1'b0, 24'h43_2100, 48'h0}, 1'b0);
      send(1'b0, {1'b1, 1'b1, 24'h11_1111, 48'h4F56_4552_4C44}, 1'b0);
      send(1'b1, {1'b0, 1'b1, 24'h22_2222, 48'h4552_524F_5231}, 1'b1);
      s_contact(4);
      s_contact(3 * GAP);
      s_rate();
      summarize();
   end

   // Run needs about 1750 cycles; allow ample margin
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      summarize();
   end
endmodule

//--- bench/cwt_host_rx.sv
// Host serial receiver model: takes framer bytes, keeps them in order.
// Assumes ref_clk and reset_n shared with the framer under test.
`timescale 1ns/1ps

module cwt_host_rx (
   input  wire logic       ref_clk,   // Framer clock
   input  wire logic       reset_n,   // Synchronous reset, active low
   input  wire logic       slow,      // 1 stalls every other cycle
   input  wire logic [7:0] tx_data,   // Byte offered
   input  wire logic       tx_valid,  // Byte offered flag
   output logic            tx_ready   // Byte taken this edge
);
   logic [7:0] rx_q[$];

   // Ready changes only after an edge, so an offered byte is never lost
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         tx_ready <= 1'b0;
      end else begin
         if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            rx_q.push_back(tx_data);
         end
         tx_ready <= slow ? ~tx_ready : 1'b1;
      end
   end
endmodule

//--- logic/cwt_defines.svh
// Character codes, frame positions and timing for the weight string framer.
// Assumes a 20 MHz ref_clk; included by the framer.
//
// Overview of operation
// - A configuration input selects plain or framed checksummed string format.
// - Strings may be emitted continuously at up to 300 per second.
// - Serial line runs at 38400 baud or faster, same rate both ends.
// - Weight field is six ASCII decimal digits unless sign or alarm applies.
// - Plain format ends the six weight characters with CR then LF.
// - Negative weight puts a minus sign in the leftmost field character.
// - On alarm a six-character alarm message replaces the weight field.
// - Framed format starts every string with the ampersand start character.
// - Framed body is T, weight field, P, weight field, both gross weight.
// - Framed format puts the backslash separator after the second field.
// - Checksum covers only characters strictly between start and separator.
// - Checksum byte is the XOR of all included 8-bit character codes.
// - Checksum goes out as two uppercase ASCII hexadecimal digits.
// - Framed string ends with CR after the checksum, no line feed.
// - One external contact closure, up to a second, sends one string.
`ifndef CWT_DEFINES_SVH
`define CWT_DEFINES_SVH

`define CWT_CH_START     8'h26
`define CWT_CH_TAG_A     8'h54
`define CWT_CH_TAG_B     8'h50
`define CWT_CH_SEP       8'h5C
`define CWT_CH_CR        8'h0D
`define CWT_CH_LF        8'h0A
`define CWT_CH_MINUS     8'h2D
`define CWT_CH_ZERO      8'h30
`define CWT_CH_NINE      8'h39
`define CWT_CH_HEX_A     8'h41
`define CWT_CH_HEX_F     8'h46
`define CWT_HEX_ALPHA    8'h37

`define CWT_POS_TAG_A    5'h01
`define CWT_POS_FLD_A    5'h02
`define CWT_POS_TAG_B    5'h08
`define CWT_POS_FLD_B    5'h09
`define CWT_POS_LAST_SUM 5'h0E
`define CWT_POS_SEP      5'h0F
`define CWT_POS_HEX_HI   5'h10
`define CWT_POS_HEX_LO   5'h11
`define CWT_POS_CR_FRM   5'h12
`define CWT_POS_CR_PLN   5'h06
`define CWT_POS_LF_PLN   5'h07
`define CWT_LEN_FRAMED   5'h13
`define CWT_LEN_PLAIN    5'h08

`define CWT_CLK_HZ       20000000
`define CWT_STRINGS_PS   300
`define CWT_BAUD_MIN     38400
`define CWT_GAP_CYC      ((`CWT_CLK_HZ + `CWT_STRINGS_PS - 1) / `CWT_STRINGS_PS)
`define CWT_BAUD_CYC     (`CWT_CLK_HZ / `CWT_BAUD_MIN)

`endif

//--- logic/cwt_framer.sv
// Continuous weight string framer: builds plain or checksummed strings
// byte by byte for a downstream bit-level serial transmitter.
// Assumes weight and tx_ready come from ref_clk logic; contact_in is a pin.
`timescale 1ns/1ps
`include "cwt_defines.svh"

module cwt_framer
   import cwt_pkg::*;
#(
   parameter int STRING_GAP_CYC = `CWT_GAP_CYC,
   parameter int BAUD_DIV       = `CWT_BAUD_CYC
) (
   input  wire logic        ref_clk,     // 20 MHz clock
   input  wire logic        reset_n,     // Synchronous reset
   input  wire logic        framed_sel,  // 1 framed, 0 plain format
   input  wire logic        stream_en,   // Continuous streaming on
   input  wire logic        contact_in,  // External contact, 1 closed
   input  wire cwt_weight_t weight,      // Current gross weight
   input  wire logic        tx_ready,    // Transmitter takes a byte
   output logic [7:0]       tx_data,     // Byte to transmit
   output logic             tx_valid,    // Byte offered
   output logic             baud_tick,   // One-cycle bit-rate enable
   output logic             busy         // String in progress
);

   cwt_state_t st_r;
   cwt_state_t st_nxt;
   logic       fire;
   logic       trig_edge;
   logic [4:0] len;

   function automatic logic [7:0] hex_char(input logic [3:0] n);
      if (n < 4'hA) begin
         return `CWT_CH_ZERO + {4'h0, n};
      end
      return `CWT_HEX_ALPHA + {4'h0, n};
   endfunction

   function automatic logic [7:0] fld_char(input logic [47:0] f,
                                           input logic [2:0]  k);
      return f[(5 - int'(k)) * 8 +: 8];
   endfunction

   // Byte at a given position of the string being sent
   function automatic logic [7:0] frame_byte(input logic        fmt,
                                             input logic [4:0]  pos,
                                             input logic [47:0] f,
                                             input logic [7:0]  cs);
      logic [7:0] b;
      b = `CWT_CH_CR;
      if (fmt) begin
         if (pos == 5'h00) begin
            b = `CWT_CH_START;
         end else if (pos == `CWT_POS_TAG_A) begin
            b = `CWT_CH_TAG_A;
         end else if (pos < `CWT_POS_TAG_B) begin
            b = fld_char(f, 3'(pos - `CWT_POS_FLD_A));
         end else if (pos == `CWT_POS_TAG_B) begin
            b = `CWT_CH_TAG_B;
         end else if (pos <= `CWT_POS_LAST_SUM) begin
            b = fld_char(f, 3'(pos - `CWT_POS_FLD_B));
         end else if (pos == `CWT_POS_SEP) begin
            b = `CWT_CH_SEP;
         end else if (pos == `CWT_POS_HEX_HI) begin
            b = hex_char(cs[7:4]);
         end else if (pos == `CWT_POS_HEX_LO) begin
            b = hex_char(cs[3:0]);
         end else begin
            b = `CWT_CH_CR;
         end
      end else begin
         if (pos < `CWT_POS_CR_PLN) begin
            b = fld_char(f, pos[2:0]);
         end else if (pos == `CWT_POS_CR_PLN) begin
            b = `CWT_CH_CR;
         end else begin
            b = `CWT_CH_LF;
         end
      end
      return b;
   endfunction

   // Six ASCII characters from the current sample
   function automatic logic [47:0] make_field(input cwt_weight_t w);
      logic [47:0] f;
      f = '0;
      for (int i = 0; i < 6; i++) begin
         f[i * 8 +: 8] = `CWT_CH_ZERO + {4'h0, w.bcd[i * 4 +: 4]};
      end
      if (w.neg) begin
         f[47:40] = `CWT_CH_MINUS;
      end
      if (w.alarm) begin
         f = w.alarm_text;
      end
      return f;
   endfunction

   assign fire      = st_r.tx_valid & tx_ready;
   assign trig_edge = st_r.trig_s[1] & ~st_r.trig_q;
   assign len       = st_r.fmt ? `CWT_LEN_FRAMED : `CWT_LEN_PLAIN;

   always_comb begin
      st_nxt = st_r;
      // Bit-rate enable for the transmitter, never slower than 38400
      st_nxt.baud_tick = 1'b0;
      if (st_r.baud_cnt == 16'h0000) begin
         st_nxt.baud_cnt  = 16'(BAUD_DIV - 1);
         st_nxt.baud_tick = 1'b1;
      end else begin
         st_nxt.baud_cnt = st_r.baud_cnt - 16'h0001;
      end
      st_nxt.trig_s = {st_r.trig_s[0], contact_in};
      st_nxt.trig_q = st_r.trig_s[1];
      if (st_r.pace != 24'h0000) begin
         st_nxt.pace = st_r.pace - 24'h0001;
      end
      if (fire) begin
         st_nxt.tx_valid = 1'b0;
      end
      case (st_r.phase)
         CWT_IDLE: begin
            // Pacing holds string starts at least STRING_GAP_CYC cycles apart, 300 per second at most by default
            if (st_r.pace == 24'h0000 && !st_r.tx_valid &&
                (stream_en || st_r.pending)) begin
               st_nxt.phase   = CWT_SEND;
               st_nxt.fmt     = framed_sel;
               st_nxt.idx     = 5'h00;
               st_nxt.csum    = 8'h00;
               // One snapshot feeds both fields and the checksum
               st_nxt.field   = make_field(weight);
               st_nxt.neg_s   = weight.neg;
               st_nxt.alarm_s = weight.alarm;
               st_nxt.pace    = 24'(STRING_GAP_CYC - 1);
               st_nxt.pending = 1'b0;
            end
         end
         CWT_SEND: begin
            if (!st_r.tx_valid || fire) begin
               if (st_r.idx == len) begin
                  st_nxt.phase = CWT_IDLE;
               end else begin
                  st_nxt.tx_data  = frame_byte(st_r.fmt, st_r.idx,
                                               st_r.field, st_r.csum);
                  st_nxt.tx_valid = 1'b1;
                  st_nxt.tx_pos   = st_r.idx;
                  st_nxt.idx      = st_r.idx + 5'h01;
                  if (st_r.idx >= `CWT_POS_TAG_A &&
                      st_r.idx <= `CWT_POS_LAST_SUM) begin
                     st_nxt.csum = st_r.csum ^
                        frame_byte(st_r.fmt, st_r.idx, st_r.field,
                                   st_r.csum);
                  end
               end
            end
         end
         default: begin
            st_nxt.phase = CWT_IDLE;
         end
      endcase
      // A closure landing on the clearing cycle still counts
      if (trig_edge) begin
         st_nxt.pending = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tx_data   = st_r.tx_data;
   assign tx_valid  = st_r.tx_valid;
   assign baud_tick = st_r.baud_tick;
   assign busy      = (st_r.phase == CWT_SEND);

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   property p_start_char;
      fire && st_r.fmt && st_r.tx_pos == 5'h00 |->
         tx_data == `CWT_CH_START;
   endproperty
   a_start_char: assert property (p_start_char)
      else $error("framed string did not open with start char");

   property p_tags;
      fire && st_r.fmt && (st_r.tx_pos == `CWT_POS_TAG_A ||
         st_r.tx_pos == `CWT_POS_TAG_B) |->
         tx_data == (st_r.tx_pos == `CWT_POS_TAG_A ?
                     `CWT_CH_TAG_A : `CWT_CH_TAG_B);
   endproperty
   a_tags: assert property (p_tags)
      else $error("identifier letter wrong");

   property p_sep;
      fire && st_r.fmt && st_r.tx_pos == `CWT_POS_SEP |->
         tx_data == `CWT_CH_SEP;
   endproperty
   a_sep: assert property (p_sep)
      else $error("separator missing");

   // Identical fields cancel, leaving the two tag letters
   property p_csum;
      fire && st_r.fmt && st_r.tx_pos == `CWT_POS_SEP |->
         st_r.csum == (`CWT_CH_TAG_A ^ `CWT_CH_TAG_B);
   endproperty
   a_csum: assert property (p_csum)
      else $error("checksum value wrong");

   // Expected digits follow from the tag letters alone, not from hex_char
   property p_hex_hi;
      fire && st_r.fmt && st_r.tx_pos == `CWT_POS_HEX_HI |->
         tx_data == `CWT_CH_ZERO + ((`CWT_CH_TAG_A ^ `CWT_CH_TAG_B) >> 4);
   endproperty
   a_hex_hi: assert property (p_hex_hi)
      else $error("high checksum digit not first");

   property p_hex_lo;
      fire && st_r.fmt && st_r.tx_pos == `CWT_POS_HEX_LO |->
         tx_data == `CWT_CH_ZERO + ((`CWT_CH_TAG_A ^ `CWT_CH_TAG_B) & 8'h0F);
   endproperty
   a_hex_lo: assert property (p_hex_lo)
      else $error("low checksum digit wrong");

   property p_hex_set;
      fire && st_r.fmt && (st_r.tx_pos == `CWT_POS_HEX_HI ||
         st_r.tx_pos == `CWT_POS_HEX_LO) |->
         (tx_data >= `CWT_CH_ZERO && tx_data <= `CWT_CH_NINE) ||
         (tx_data >= `CWT_CH_HEX_A && tx_data <= `CWT_CH_HEX_F);
   endproperty
   a_hex_set: assert property (p_hex_set)
      else $error("checksum digit not uppercase hex");

   property p_frm_end;
      fire && st_r.fmt && st_r.tx_pos == `CWT_POS_CR_FRM |->
         tx_data == `CWT_CH_CR ##1 !busy && !tx_valid;
   endproperty
   a_frm_end: assert property (p_frm_end)
      else $error("framed string end wrong");

   property p_pln_end;
      fire && !st_r.fmt && st_r.tx_pos == `CWT_POS_CR_PLN |->
         tx_data == `CWT_CH_CR ##[1:300] fire && tx_data == `CWT_CH_LF;
   endproperty
   a_pln_end: assert property (p_pln_end)
      else $error("plain string end wrong");

   property p_digits;
      fire && busy && !st_r.alarm_s && !st_r.fmt &&
         st_r.tx_pos < `CWT_POS_CR_PLN &&
         !(st_r.neg_s && st_r.tx_pos == 5'h00) |->
         tx_data >= `CWT_CH_ZERO && tx_data <= `CWT_CH_NINE;
   endproperty
   a_digits: assert property (p_digits)
      else $error("weight character not a digit");

   property p_minus;
      fire && !st_r.alarm_s && st_r.neg_s &&
         st_r.tx_pos == (st_r.fmt ? `CWT_POS_FLD_A : 5'h00) |->
         tx_data == `CWT_CH_MINUS;
   endproperty
   a_minus: assert property (p_minus)
      else $error("minus sign missing");

   property p_minus_b;
      fire && st_r.fmt && !st_r.alarm_s && st_r.neg_s &&
         st_r.tx_pos == `CWT_POS_FLD_B |->
         tx_data == `CWT_CH_MINUS;
   endproperty
   a_minus_b: assert property (p_minus_b)
      else $error("minus sign missing in second field");

   property p_frm_digits;
      fire && st_r.fmt && !st_r.alarm_s &&
         ((st_r.tx_pos >= `CWT_POS_FLD_A && st_r.tx_pos < `CWT_POS_TAG_B) ||
          (st_r.tx_pos >= `CWT_POS_FLD_B &&
           st_r.tx_pos <= `CWT_POS_LAST_SUM)) &&
         !(st_r.neg_s && (st_r.tx_pos == `CWT_POS_FLD_A ||
                          st_r.tx_pos == `CWT_POS_FLD_B)) |->
         tx_data >= `CWT_CH_ZERO && tx_data <= `CWT_CH_NINE;
   endproperty
   a_frm_digits: assert property (p_frm_digits)
      else $error("framed weight character not a digit");

   // Nothing may follow the line feed of a plain string
   property p_pln_done;
      fire && !st_r.fmt && st_r.tx_pos == `CWT_POS_LF_PLN |=>
         !busy && !tx_valid;
   endproperty
   a_pln_done: assert property (p_pln_done)
      else $error("plain string ran past line feed");

   // A stalled byte must not change before it is taken
   property p_hold;
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
   endproperty
   a_hold: assert property (p_hold)
      else $error("offered byte changed while stalled");

   property p_format;
      !busy ##1 busy |-> st_r.fmt == $past(framed_sel);
   endproperty
   a_format: assert property (p_format)
      else $error("format not taken from selection");

   property p_gap;
      !busy && st_r.pace != 24'h0000 |=> !busy;
   endproperty
   a_gap: assert property (p_gap)
      else $error("string started inside pacing gap");

   property p_trigger;
      $rose(st_r.trig_s[1]) |=> st_r.pending || busy;
   endproperty
   a_trigger: assert property (p_trigger)
      else $error("contact closure lost");

endmodule

//--- logic/cwt_pkg.sv
// Types shared by the weight string framer.
// Assumes cwt_defines.svh sits on the include path.
package cwt_pkg;

   typedef enum logic {
      CWT_IDLE,
      CWT_SEND
   } cwt_phase_t;

   // Weight sample as offered by the measuring logic
   typedef struct packed {
      logic          neg;
      logic          alarm;
      logic [23:0]   bcd;
      logic [47:0]   alarm_text;
   } cwt_weight_t;

   typedef struct packed {
      cwt_phase_t    phase;
      logic          fmt;
      logic [4:0]    idx;
      logic [4:0]    tx_pos;
      logic [47:0]   field;
      logic          neg_s;
      logic          alarm_s;
      logic [7:0]    csum;
      logic [1:0]    trig_s;
      logic          trig_q;
      logic          pending;
      logic [23:0]   pace;
      logic [15:0]   baud_cnt;
      logic          baud_tick;
      logic [7:0]    tx_data;
      logic          tx_valid;
   } cwt_state_t;

endpackage
